// file: hdl/mbrs_modbus_slave.sv
`timescale 1ns/1ns
`include "mbrs_defs.svh"

module mbrs_modbus_slave
    import mbrs_pkg::*;
#(
    parameter int GAP_CYCLES = int'(`MBRS_GAP_CYCLES)
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Configuration
    input wire logic [7:0] own_addr,
    // Received byte stream
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    // Transmitted byte stream
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    // Register table port
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_value_ok
);
    // ==========================================================
    // Checksum step: eight data bits only, eight shifts per byte
    function automatic logic [15:0] crc_step(input logic [15:0] crc_in, input logic [7:0] data);
        logic [15:0] c;
        c = crc_in ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ `MBRS_CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    // ==========================================================
    // State
    mbrs_state_e state_reg;
    mbrs_kind_e kind_reg;
    logic [31:0] gap_reg;
    logic [7:0] len_reg;
    logic [15:0] rx_crc_reg;
    logic [7:0] hdr_reg [7];
    logic [7:0] exc_reg;
    logic [15:0] cur_reg;
    logic [6:0] cnt_reg;
    logic [6:0] ptr_reg;
    logic wpass_reg;
    logic [7:0] whi_reg;
    logic [15:0] word_reg;
    logic [2:0] idx_reg;
    logic [15:0] reg_addr_reg;
    logic [15:0] reg_wdata_reg;
    logic reg_wr_reg;
    logic reg_rd_reg;
    logic [7:0] tx_data_reg;
    logic tx_valid_reg;
    logic [15:0] tx_crc_reg;
    logic [7:0] mem_rdata;

    // ==========================================================
    // Receive side decode
    wire in_rx = (state_reg == S_RX);
    wire rx_take = in_rx & rx_valid;
    wire gap_full = (gap_reg >= 32'(GAP_CYCLES - 1));
    wire frame_end = in_rx & ~rx_valid & (len_reg != 8'h00) & gap_full;
    wire mem_wr = rx_take & (len_reg >= `MBRS_HDR_LEN) & (len_reg < (`MBRS_HDR_LEN + 8'h80));
    wire [7:0] mem_off = len_reg - `MBRS_HDR_LEN;

    // Idle gap counter, cleared by every byte and outside reception
    always_ff @(posedge clock) begin
        if (rst || !in_rx || rx_valid) begin
            gap_reg <= 32'h0000_0000;
        end else if (!gap_full) begin
            gap_reg <= gap_reg + 32'h0000_0001;
        end
    end

    // Length and running checksum; bytes during a reply are ignored
    always_ff @(posedge clock) begin
        if (rst) begin
            len_reg <= 8'h00;
            rx_crc_reg <= `MBRS_CRC_INIT;
        end else if (rx_take) begin
            len_reg <= (len_reg == `MBRS_LEN_MAX) ? len_reg : len_reg + 8'h01;
            rx_crc_reg <= crc_step((len_reg == 8'h00) ? `MBRS_CRC_INIT : rx_crc_reg, rx_data);
        end else if (state_reg == S_EVAL) begin
            len_reg <= 8'h00;
        end
    end

    // First seven bytes kept in flops for decoding
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < 7; i++) begin
                hdr_reg[i] <= 8'h00;
            end
        end else if (rx_take && len_reg < `MBRS_HDR_LEN) begin
            hdr_reg[len_reg[2:0]] <= rx_data;
        end
    end

    // Payload of multi writes lives in the frame store
    mbrs_frame_mem u_mem (
        .clock(clock),
        .rst(rst),
        .wr_en(mem_wr),
        .wr_addr(mem_off[`MBRS_MEM_AW-1:0]),
        .wr_data(rx_data),
        .rd_addr(ptr_reg),
        .rd_data(mem_rdata)
    );

    // ==========================================================
    // Frame evaluation, fields are high byte first
    wire [7:0] func = hdr_reg[1];
    wire [15:0] start = {hdr_reg[2], hdr_reg[3]};
    wire [15:0] count = {hdr_reg[4], hdr_reg[5]};
    wire is_rd = (func == `MBRS_FN_READ);
    wire is_w1 = (func == `MBRS_FN_WR1);
    wire is_wn = (func == `MBRS_FN_WRN);
    wire crc_ok = (rx_crc_reg == `MBRS_CRC_RESIDUE);
    wire drop = (len_reg < `MBRS_MIN_LEN) | (hdr_reg[0] != own_addr) | ~crc_ok;
    wire cnt_ok = is_w1 | ((count != 16'h0000) & (count <= `MBRS_MAX_REGS));
    wire bc_ok = (hdr_reg[6] == {count[6:0], 1'b0}) & ({1'b0, len_reg} == {1'b0, hdr_reg[6]} + `MBRS_WRN_OVH);
    wire len_ok = is_wn ? bc_ok : (len_reg == `MBRS_FIX_LEN);
    wire [16:0] span_end = {1'b0, start} + (is_w1 ? 17'h00001 : {1'b0, count});
    wire range_ok = (span_end <= `MBRS_REG_COUNT);
    wire [7:0] exc_code = ~(is_rd | is_w1 | is_wn) ? `MBRS_EXC_FUNC :
                          ~(len_ok & cnt_ok) ? `MBRS_EXC_VAL :
                          ~range_ok ? `MBRS_EXC_ADDR : `MBRS_EXC_NONE;
    wire [6:0] first_cnt = is_w1 ? 7'h01 : count[6:0];

    // ==========================================================
    // Transmit byte selection
    wire [2:0] hdr_last = (kind_reg == K_ECHO) ? `MBRS_ECHO_LAST : `MBRS_SHORT_LAST;
    wire [7:0] hdr_byte =
        (idx_reg == 3'h0) ? hdr_reg[0] :
        (idx_reg == 3'h1) ? ((kind_reg == K_EXC) ? func + `MBRS_EXC_ADD : func) :
        (idx_reg == 3'h2) ? ((kind_reg == K_EXC) ? exc_reg :
                             (kind_reg == K_READ) ? {cnt_reg, 1'b0} : hdr_reg[2]) :
        (idx_reg == 3'h3) ? hdr_reg[3] :
        (idx_reg == 3'h4) ? hdr_reg[4] : hdr_reg[5];
    wire is_crc_st = (state_reg == S_CRC_LO) | (state_reg == S_CRC_HI);
    wire is_send = (state_reg == S_TXH) | (state_reg == S_TXD_HI) | (state_reg == S_TXD_LO) | is_crc_st;
    // Low checksum byte leaves first: the byte exchange of the final code
    wire [7:0] send_byte =
        (state_reg == S_TXH) ? hdr_byte :
        (state_reg == S_TXD_HI) ? word_reg[15:8] :
        (state_reg == S_TXD_LO) ? word_reg[7:0] :
        (state_reg == S_CRC_LO) ? tx_crc_reg[7:0] : tx_crc_reg[15:8];
    wire tx_done = tx_valid_reg & tx_ready;

    // Byte is held until taken; one byte every two cycles at best
    always_ff @(posedge clock) begin
        if (rst) begin
            tx_valid_reg <= 1'b0;
            tx_data_reg <= 8'h00;
            tx_crc_reg <= `MBRS_CRC_INIT;
        end else if (state_reg == S_EVAL) begin
            tx_crc_reg <= `MBRS_CRC_INIT;
        end else if (is_send && !tx_valid_reg) begin
            tx_valid_reg <= 1'b1;
            tx_data_reg <= send_byte;
            if (!is_crc_st) begin
                tx_crc_reg <= crc_step(tx_crc_reg, send_byte);
            end
        end else if (tx_done) begin
            tx_valid_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Sequencer: all values are checked before the first write lands
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= S_RX;
            kind_reg <= K_EXC;
            exc_reg <= `MBRS_EXC_NONE;
            cur_reg <= 16'h0000;
            cnt_reg <= 7'h00;
            ptr_reg <= 7'h00;
            wpass_reg <= 1'b0;
            whi_reg <= 8'h00;
            word_reg <= 16'h0000;
            idx_reg <= 3'h0;
            reg_addr_reg <= 16'h0000;
            reg_wdata_reg <= 16'h0000;
            reg_wr_reg <= 1'b0;
            reg_rd_reg <= 1'b0;
        end else begin
            case (state_reg)
                S_RX: begin
                    if (frame_end) begin
                        state_reg <= S_EVAL;
                    end
                end
                S_EVAL: begin
                    idx_reg <= 3'h0;
                    cur_reg <= start;
                    cnt_reg <= first_cnt;
                    ptr_reg <= 7'h00;
                    wpass_reg <= 1'b0;
                    exc_reg <= exc_code;
                    if (drop) begin
                        state_reg <= S_RX;
                    end else if (exc_code != `MBRS_EXC_NONE) begin
                        kind_reg <= K_EXC;
                        state_reg <= S_TXH;
                    end else if (is_rd) begin
                        kind_reg <= K_READ;
                        state_reg <= S_TXH;
                    end else begin
                        state_reg <= is_w1 ? S_VUSE : S_VHI;
                    end
                end
                S_VHI: begin
                    ptr_reg <= ptr_reg + 7'h01;
                    state_reg <= S_VLO;
                end
                S_VLO: begin
                    whi_reg <= mem_rdata;
                    ptr_reg <= ptr_reg + 7'h01;
                    state_reg <= S_VUSE;
                end
                S_VUSE: begin
                    reg_addr_reg <= cur_reg;
                    reg_wdata_reg <= is_w1 ? count : {whi_reg, mem_rdata};
                    reg_wr_reg <= wpass_reg;
                    state_reg <= S_VACT;
                end
                S_VACT: begin
                    reg_wr_reg <= 1'b0;
                    if (!wpass_reg && !reg_value_ok) begin
                        exc_reg <= `MBRS_EXC_VAL;
                        kind_reg <= K_EXC;
                        state_reg <= S_TXH;
                    end else if (cnt_reg == 7'h01 && !wpass_reg) begin
                        wpass_reg <= 1'b1;
                        cur_reg <= start;
                        cnt_reg <= first_cnt;
                        ptr_reg <= 7'h00;
                        state_reg <= is_w1 ? S_VUSE : S_VHI;
                    end else if (cnt_reg == 7'h01) begin
                        kind_reg <= K_ECHO;
                        state_reg <= S_TXH;
                    end else begin
                        cur_reg <= cur_reg + 16'h0001;
                        cnt_reg <= cnt_reg - 7'h01;
                        state_reg <= S_VHI;
                    end
                end
                S_TXH: begin
                    if (tx_done) begin
                        idx_reg <= idx_reg + 3'h1;
                        if (idx_reg == hdr_last) begin
                            state_reg <= (kind_reg == K_READ) ? S_RDREQ : S_CRC_LO;
                        end
                    end
                end
                S_RDREQ: begin
                    reg_addr_reg <= cur_reg;
                    reg_rd_reg <= 1'b1;
                    state_reg <= S_RDWAIT;
                end
                S_RDWAIT: begin
                    reg_rd_reg <= 1'b0;
                    state_reg <= S_RDCAP;
                end
                S_RDCAP: begin
                    word_reg <= reg_rdata;
                    state_reg <= S_TXD_HI;
                end
                S_TXD_HI: begin
                    if (tx_done) begin
                        state_reg <= S_TXD_LO;
                    end
                end
                S_TXD_LO: begin
                    if (tx_done && cnt_reg == 7'h01) begin
                        state_reg <= S_CRC_LO;
                    end else if (tx_done) begin
                        cur_reg <= cur_reg + 16'h0001;
                        cnt_reg <= cnt_reg - 7'h01;
                        state_reg <= S_RDREQ;
                    end
                end
                S_CRC_LO: begin
                    if (tx_done) begin
                        state_reg <= S_CRC_HI;
                    end
                end
                default: begin
                    if (tx_done) begin
                        state_reg <= S_RX;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Outputs
    assign tx_data = tx_data_reg;
    assign tx_valid = tx_valid_reg;
    assign reg_addr = reg_addr_reg;
    assign reg_wdata = reg_wdata_reg;
    assign reg_wr = reg_wr_reg;
    assign reg_rd = reg_rd_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence read_issue;
        reg_rd ##1 (state_reg == S_RDCAP);
    endsequence
    sequence read_send;
        (state_reg == S_TXD_HI) ##1 (state_reg == S_TXD_HI || state_reg == S_TXD_LO);
    endsequence

    chk_tx_only_reply: assert property (tx_valid |-> !in_rx || !$past(in_rx))
        else $error("byte sent while receiving");
    chk_bad_crc_drop: assert property ((state_reg == S_EVAL && !crc_ok) |=> in_rx [*3])
        else $error("bad checksum frame not dropped");
    chk_foreign_drop: assert property ((state_reg == S_EVAL && hdr_reg[0] != own_addr) |=> in_rx && !reg_wr)
        else $error("foreign frame not dropped");
    chk_crc_start: assert property ((rx_take && len_reg == 8'h00) |=> rx_crc_reg == crc_step(16'hffff, $past(rx_data)))
        else $error("checksum not started from all ones");
    chk_exc_func: assert property ((tx_valid && state_reg == S_TXH && kind_reg == K_EXC && idx_reg == 3'h1)
        |-> tx_data == hdr_reg[1] + 8'h80)
        else $error("exception function code wrong");
    chk_wr_limit: assert property (reg_wr |-> (is_w1 || (is_wn && count <= 16'h003c)) && hdr_reg[0] == own_addr)
        else $error("write outside allowed command");
    chk_read_pair: assert property (read_issue |=> read_send)
        else $error("read word not sent high byte first");
    chk_crc_order: assert property ((state_reg == S_CRC_LO && tx_done) |=> state_reg == S_CRC_HI)
        else $error("checksum bytes out of order");
    chk_tx_hold: assert property ((tx_valid && !tx_ready) |=> tx_valid && $stable(tx_data))
        else $error("byte changed before taken");
    chk_unsupported: assert property ((state_reg == S_EVAL && !drop && !(is_rd || is_w1 || is_wn))
        |=> kind_reg == K_EXC && exc_reg == 8'h81)
        else $error("unsupported function not refused");
endmodule

// file: hdl/mbrs_defs.svh
`ifndef MBRS_DEFS_SVH
`define MBRS_DEFS_SVH

// ==========================================================
// Timing
`define MBRS_CLK_HZ 64'd50000000
`define MBRS_BAUD 64'd9600
`define MBRS_CHAR_BITS 64'd11
// Idle gap in tenths of a character time (3.5 characters)
`define MBRS_GAP_TENTHS 64'd35
// Least gap, rounded up to whole clock cycles
`define MBRS_GAP_CYCLES \
    ((`MBRS_GAP_TENTHS * `MBRS_CHAR_BITS * `MBRS_CLK_HZ + 64'd10 * `MBRS_BAUD - 64'd1) / (64'd10 * `MBRS_BAUD))

// ==========================================================
// Checksum
`define MBRS_CRC_INIT 16'hffff
`define MBRS_CRC_POLY 16'ha001
`define MBRS_CRC_RESIDUE 16'h0000

// ==========================================================
// Function and exception codes
`define MBRS_FN_READ 8'h03
`define MBRS_FN_WR1 8'h06
`define MBRS_FN_WRN 8'h10
`define MBRS_EXC_ADD 8'h80
`define MBRS_EXC_FUNC 8'h81
`define MBRS_EXC_ADDR 8'h82
`define MBRS_EXC_VAL 8'h83
`define MBRS_EXC_NONE 8'h00

// ==========================================================
// Frame layout and limits
`define MBRS_MAX_REGS 16'h003c
`define MBRS_REG_COUNT 17'h00100
`define MBRS_HDR_LEN 8'h07
`define MBRS_MIN_LEN 8'h04
`define MBRS_FIX_LEN 8'h08
`define MBRS_WRN_OVH 9'h009
`define MBRS_LEN_MAX 8'hff
`define MBRS_MEM_DEPTH 128
`define MBRS_MEM_AW 7
`define MBRS_ECHO_LAST 3'h5
`define MBRS_SHORT_LAST 3'h2

`endif

// file: hdl/mbrs_pkg.sv
package mbrs_pkg;

    // Sequencer states, Gray steps in the order listed
    typedef enum logic [3:0] {
        S_RX     = 4'h0,
        S_EVAL   = 4'h1,
        S_VHI    = 4'h3,
        S_VLO    = 4'h2,
        S_VUSE   = 4'h6,
        S_VACT   = 4'h7,
        S_RDREQ  = 4'h5,
        S_RDWAIT = 4'h4,
        S_RDCAP  = 4'hc,
        S_TXH    = 4'hd,
        S_TXD_HI = 4'hf,
        S_TXD_LO = 4'he,
        S_CRC_LO = 4'ha,
        S_CRC_HI = 4'hb
    } mbrs_state_e;

    // Reply shapes
    typedef enum logic [1:0] {
        K_EXC  = 2'h0,
        K_READ = 2'h1,
        K_ECHO = 2'h2
    } mbrs_kind_e;

endpackage

// file: hdl/mbrs_frame_mem.sv
`timescale 1ns/1ns
`include "mbrs_defs.svh"

// ==========================================================
// Frame payload store, one write and one registered read port
module mbrs_frame_mem (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Write side
    input wire logic wr_en,
    input wire logic [`MBRS_MEM_AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    // Read side
    input wire logic [`MBRS_MEM_AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [`MBRS_MEM_DEPTH];

    // Array has no reset; only bytes written this frame are read
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read data comes out of a register
    always_ff @(posedge clock) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// file: test/mbrs_partner.sv
`timescale 1ns/1ns

// ==========================================================
// Parameter storage and byte sink that sit behind the slave
module mbrs_partner #(
    parameter logic [15:0] VAL_MAX = 16'h7fff
) (
    // Clock
    input wire logic clock,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic reg_value_ok,
    // Byte sink
    input wire logic slow,
    output logic tx_ready
);
    logic [15:0] mem [0:255];
    logic [1:0] pace = 2'h0;
    int n_access = 0;

    // Upper limit stands in for a real per-parameter range table
    assign reg_value_ok = (reg_wdata <= VAL_MAX);
    // When slow, the sink takes one byte in three cycles
    assign tx_ready = !slow || (pace == 2'h2);

    // Read data holds one cycle, then is inverted each cycle so a word taken one cycle late is wrong
    always @(posedge clock) begin
        pace <= (pace == 2'h2) ? 2'h0 : pace + 2'h1;
        reg_rdata <= reg_rd ? mem[reg_addr[7:0]] : ~reg_rdata;
        if (reg_wr) begin
            mem[reg_addr[7:0]] <= reg_wdata;
        end
        if (reg_wr || reg_rd) begin
            n_access <= n_access + 1;
        end
    end
endmodule

// file: test/modbus_rtu_register_slave_test.sv
`timescale 1ns/1ns

// ==========================================================
// Frame level bench for the station slave
module modbus_rtu_register_slave_test;
    import mbrs_pkg::*;
    // Short idle gap keeps each frame to a few hundred cycles
    localparam int GAP = 20;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] own_addr = 8'h01;
    logic [7:0] rx_data = 8'h00;
    logic rx_valid = 1'b0;
    logic slow = 1'b0;
    logic [7:0] tx_data;
    logic tx_valid;
    logic tx_ready;
    logic [15:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic reg_value_ok;
    logic [7:0] got[$];
    logic [7:0] none[$];
    int miscompares = 0;
    int n_checks = 0;

    always #10 clock = ~clock;

    mbrs_modbus_slave #(.GAP_CYCLES(GAP)) dut (.clock(clock), .rst(rst), .own_addr(own_addr),
        .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_value_ok(reg_value_ok));

    mbrs_partner ptn (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_value_ok(reg_value_ok), .slow(slow),
        .tx_ready(tx_ready));

    // Reply bytes as the sink accepts them
    always @(posedge clock) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            got.push_back(tx_data);
        end
    end

    // Reference checksum, bytes only, low byte goes out first
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) begin
                c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
            end
        end
        return c;
    endfunction

    task automatic check(string what, logic [15:0] exp, logic [15:0] seen);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One byte per two cycles, well inside the gap; bad flips a checksum bit
    task automatic send(logic [7:0] f[$], bit bad);
        logic [15:0] c;
        c = crc16(f);
        f.push_back(c[7:0]);
        f.push_back(c[15:8] ^ {7'h00, bad});
        got.delete();
        foreach (f[i]) begin
            @(negedge clock);
            rx_data = f[i];
            rx_valid = 1'b1;
            @(negedge clock);
            rx_valid = 1'b0;
        end
    endtask

    // Waits bounded, then also confirms nothing extra follows
    task automatic expect_reply(string what, logic [7:0] e[$]);
        logic [15:0] c;
        int t;
        if (e.size() > 0) begin
            c = crc16(e);
            e.push_back(c[7:0]);
            e.push_back(c[15:8]);
        end
        t = 0;
        while (got.size() < e.size() && t < GAP + 2000) begin
            @(negedge clock);
            t++;
        end
        repeat (GAP + 100) @(negedge clock);
        check({what, " length"}, 16'(e.size()), 16'(got.size()));
        foreach (e[i]) begin
            if (i < got.size()) begin
                check(what, {8'h00, e[i]}, {8'h00, got[i]});
            end
        end
        $display("test %s done", what);
    endtask

    // A frame that must leave storage untouched
    task automatic refuse(string what, logic [7:0] f[$], bit bad, logic [7:0] e[$]);
        int a;
        a = ptn.n_access;
        send(f, bad);
        expect_reply(what, e);
        check({what, " access"}, 16'(a), 16'(ptn.n_access));
    endtask

    task automatic t_read;
        ptn.mem[8'h16] = 16'h1784;
        ptn.mem[8'h17] = 16'h1780;
        ptn.mem[8'h18] = 16'h178a;
        // Known frame anchors the reference checksum independently
        check("crc ref", 16'h0914, crc16('{8'h01, 8'h03, 8'h00, 8'h09, 8'h00, 8'h02}));
        slow = 1'b1;
        send('{8'h01, 8'h03, 8'h00, 8'h16, 8'h00, 8'h03}, 1'b0);
        expect_reply("read", '{8'h01, 8'h03, 8'h06, 8'h17, 8'h84, 8'h17, 8'h80, 8'h17, 8'h8a});
        slow = 1'b0;
    endtask

    task automatic t_write1;
        send('{8'h01, 8'h06, 8'h00, 8'h2c, 8'h07, 8'hd0}, 1'b0);
        expect_reply("write one", '{8'h01, 8'h06, 8'h00, 8'h2c, 8'h07, 8'hd0});
        check("word 2c", 16'h07d0, ptn.mem[8'h2c]);
    endtask

    task automatic t_writen;
        send('{8'h01, 8'h10, 8'h00, 8'h2c, 8'h00, 8'h02, 8'h04, 8'h04, 8'hb0, 8'h13, 8'h88}, 1'b0);
        expect_reply("write many", '{8'h01, 8'h10, 8'h00, 8'h2c, 8'h00, 8'h02});
        check("word 2c", 16'h04b0, ptn.mem[8'h2c]);
        check("word 2d", 16'h1388, ptn.mem[8'h2d]);
    endtask

    // Count at and just past the per-command limit
    task automatic t_bulk(int n);
        logic [7:0] f[$];
        int a;
        a = ptn.n_access;
        f = '{8'h01, 8'h10, 8'h00, 8'h40, 8'h00, 8'(n), 8'(2 * n)};
        for (int k = 0; k < n; k++) begin
            f.push_back(8'h00);
            f.push_back(8'(k));
        end
        send(f, 1'b0);
        if (n <= 60) begin
            expect_reply("bulk", '{8'h01, 8'h10, 8'h00, 8'h40, 8'h00, 8'(n)});
            check("last word", 16'(n - 1), ptn.mem[8'(8'h40 + n - 1)]);
        end else begin
            expect_reply("bulk over", '{8'h01, 8'h90, 8'h83});
            check("bulk access", 16'(a), 16'(ptn.n_access));
        end
    endtask

    task automatic t_bad_crc;
        refuse("bad crc", '{8'h01, 8'h06, 8'h00, 8'h2c, 8'h11, 8'h11}, 1'b1, none);
        check("word kept", 16'h04b0, ptn.mem[8'h2c]);
    endtask

    task automatic t_foreign;
        refuse("foreign", '{8'h02, 8'h03, 8'h00, 8'h16, 8'h00, 8'h01}, 1'b0, none);
        // Same frame is answered once the station address matches
        own_addr = 8'h02;
        send('{8'h02, 8'h03, 8'h00, 8'h16, 8'h00, 8'h01}, 1'b0);
        expect_reply("own addr", '{8'h02, 8'h03, 8'h02, 8'h17, 8'h84});
        own_addr = 8'h01;
    endtask

    task automatic t_exc;
        refuse("bad func", '{8'h01, 8'h04, 8'h00, 8'h16, 8'h00, 8'h01}, 1'b0, '{8'h01, 8'h84, 8'h81});
        refuse("bad range", '{8'h01, 8'h03, 8'h00, 8'hff, 8'h00, 8'h02}, 1'b0, '{8'h01, 8'h83, 8'h82});
        refuse("bad value", '{8'h01, 8'h06, 8'h00, 8'h2c, 8'h80, 8'h00}, 1'b0, '{8'h01, 8'h86, 8'h83});
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence, inputs change on the falling edge
    initial begin
        repeat (3) @(negedge clock);
        rst = 1'b0;
        t_read;
        t_write1;
        t_writen;
        t_bulk(60);
        t_bulk(61);
        t_bad_crc;
        t_foreign;
        t_exc;
        wrap_up;
    end

    // Whole run needs a few thousand cycles; this is far beyond that
    initial begin
        #(20 * 60000);
        miscompares++;
        $display("watchdog expired");
        wrap_up;
    end
endmodule
